// *** logic/mda_pkg.sv ***
// constants and types for the multiplexed dram access controller
// Function
// - chip select decoded from the per-bank row strobes, column strobe shared
// - all 128 rows refreshed every 2 ms
// - page cycles 160 ns, column precharge 60 ns
// - data hold 40 ns from its strobe edge
// - row hold 15 ns, column hold 40 ns
// - random cycles 320 ns apart
// - read keeps write select high throughout
// - write select low 40 ns, lead 50 ns
// - write select low before column strobe
// - page mode keeps row strobe low
package mda_pkg;
  localparam int CLK_NS = 10;
  // ----------------------------------------------------------------
  // timing figures in ns and their cycle counts
  // ----------------------------------------------------------------
  localparam int ROW_HOLD_NS      = 15;
  localparam int ROW_TO_COL_MAX_NS = 40;
  localparam int COL_ACCESS_NS    = 80;
  localparam int COL_HOLD_NS      = 40;
  localparam int CYCLE_NS         = 320;
  localparam int PAGE_CYCLE_NS    = 160;
  localparam int PAGE_PRE_NS      = 60;
  localparam int ROW_PRE_NS       = 100;
  localparam int WR_LEAD_NS       = 50;
  localparam int TURNOFF_NS       = 35;
  localparam int REFRESH_MS       = 2;
  localparam int REFRESH_ROWS     = 128;
  // least times round up
  localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_ACC_CYC  = (COL_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_HOLD_CYC = (COL_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCLE_CYC    = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_CYC     = (PAGE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_PRE_CYC = (PAGE_PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_PRE_CYC  = (ROW_PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_LEAD_CYC  = (WR_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TURNOFF_CYC  = (TURNOFF_NS + CLK_NS - 1) / CLK_NS;
  // data bit synchroniser depth, added to every read wait
  localparam int SYNC_CYC     = 2;
  // refresh interval per row, rounded down so the window is met
  localparam int REFRESH_CYC_DEF =
    (REFRESH_MS * 1000000 / CLK_NS) / REFRESH_ROWS;
  localparam int CNT_W  = 12;
  localparam int ADDR_W = 7;
  localparam int ROW_W  = 7;
  localparam int WORD_W = 14;
  localparam logic [ROW_W-1:0] ROW_RST = 7'h00;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ROW, ST_COL, ST_ACC, ST_WRITE, ST_PAGE_PRE,
    ST_REF, ST_PRE
  } mda_state_t;
endpackage

// *** logic/mda_ctrl.sv ***
// host controller sequencing a multiplexed dynamic ram
`timescale 1ns/1ns
`default_nettype none
module mda_ctrl (
  input  wire logic                      clock,
  input  wire logic                      rst,
  // user request side
  input  wire logic                      req_valid,
  input  wire logic                      req_write,
  input  wire logic                      req_page,
  input  wire logic                      req_sel,
  input  wire logic [mda_pkg::WORD_W-1:0] req_addr,
  input  wire logic                      req_wdata,
  output logic                           req_ready,
  output logic                           rsp_valid,
  output logic                           rsp_rdata,
  output logic                           refresh_busy,
  // memory pins
  output logic [1:0]                     row_latch_strobe_n,
  output logic                           column_strobe_n,
  output logic                           write_select_n,
  output logic [mda_pkg::ADDR_W-1:0]     multiplexed_address_lines,
  output logic                           data_in,
  input  wire logic                      data_out
);
  import mda_pkg::*;

  // ----------------------------------------------------------------
  // sequence of one access, in clock edges from acceptance
  // ----------------------------------------------------------------
  // 0   request taken, row address driven onto the shared lines
  // 1   row strobe of the selected bank falls
  // 4   column address, write select and data bit driven
  // 5   column strobe falls; an early write is captured here
  // ..  column held until the bit has passed the synchroniser and
  //     the row has been open for the random cycle less the row precharge
  // n   column and row strobes rise together, result returned
  // n+1 write select released, then row precharge, back to idle
  // the row address stays on the lines until the third edge after
  // the row strobe falls, which covers the row hold with margin
  // a page continuation keeps the row strobe low and only cycles the
  // column strobe; it is refused whenever a refresh is pending, so a
  // long page burst can never starve the refresh timer
  // limitation: only early writes are issued, so the memory output
  // stays released on writes and delayed write timing is never used

  mda_state_t             state_q;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cyc_q;   // cycles since row strobe fell
  logic [CNT_W-1:0]       ref_q;   // refresh interval timer
  logic                   ref_pend_q;
  logic [ROW_W-1:0]       ref_row_q;
  logic [ROW_W-1:0]       row_q;
  logic                   sel_q;
  logic                   wr_q;
  logic                   dout_s1_q;
  logic                   dout_s2_q;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  // ----------------------------------------------------------------
  // data bit synchroniser, second stage only is read
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dout_s1_q <= 1'b0;
      dout_s2_q <= 1'b0;
    end else begin
      dout_s1_q <= data_out;
      dout_s2_q <= dout_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // refresh interval timer and row counter
  // ----------------------------------------------------------------
  // pending request stays set until a refresh cycle consumes it;
  // a new tick in that cycle wins over the clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_q      <= '0;
      ref_pend_q <= 1'b0;
    end else begin
      if (ref_q == cyc(REFRESH_CYC_DEF - 1)) begin
        ref_q      <= '0;
        ref_pend_q <= 1'b1;
      end else begin
        ref_q <= ref_q + 1'b1;
        if (state_q == ST_REF && cnt_q == '0)
          ref_pend_q <= 1'b0;
      end
    end
  end

  // step once, on the last precharge cycle of a refresh; stepping on
  // every precharge cycle would stride across rows instead of walking
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      ref_row_q <= ROW_RST;
    else if (state_q == ST_PRE && refresh_busy && cnt_q == '0)
      ref_row_q <= ref_row_q + 1'b1; // walk all rows
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q                   <= ST_IDLE;
      cnt_q                     <= '0;
      cyc_q                     <= '0;
      row_q                     <= '0;
      sel_q                     <= 1'b0;
      wr_q                      <= 1'b0;
      req_ready                 <= 1'b0;
      rsp_valid                 <= 1'b0;
      rsp_rdata                 <= 1'b0;
      refresh_busy              <= 1'b0;
      row_latch_strobe_n        <= 2'b11;
      column_strobe_n           <= 1'b1;
      write_select_n            <= 1'b1;
      multiplexed_address_lines <= '0;
      data_in                   <= 1'b0;
    end else begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      cyc_q     <= cyc_q + 1'b1;
      if (cnt_q != '0)
        cnt_q <= cnt_q - 1'b1;
      case (state_q)
        ST_IDLE: begin
          if (ref_pend_q) begin // refresh first
            multiplexed_address_lines <= ref_row_q;
            refresh_busy <= 1'b1;
            state_q      <= ST_ROW;
          end else if (req_valid) begin
            multiplexed_address_lines <= req_addr[ROW_W-1:0];
            row_q     <= req_addr[ROW_W-1:0];
            sel_q     <= req_sel;
            req_ready <= 1'b1;
            state_q   <= ST_ROW;
          end
        end
        ST_ROW: begin
          // address was set up a cycle before the strobe falls
          if (refresh_busy)
            row_latch_strobe_n <= 2'b00; // refresh every bank
          else
            row_latch_strobe_n <= sel_q ? 2'b01 : 2'b10;
          cyc_q <= '0;
          cnt_q <= cyc(ROW_HOLD_CYC);
          state_q <= refresh_busy ? ST_REF : ST_COL;
        end
        ST_REF: begin
          // row-only cycle, column strobe held high
          if (cyc_q >= cyc(CYCLE_CYC - ROW_PRE_CYC - 1)) begin
            row_latch_strobe_n <= 2'b11;
            cnt_q   <= cyc(ROW_PRE_CYC);
            state_q <= ST_PRE;
          end
        end
        ST_COL: begin
          if (cnt_q == '0) begin // row held 15 ns
            multiplexed_address_lines <= req_addr[WORD_W-1:ROW_W];
            wr_q           <= req_write;
            data_in        <= req_wdata;
            write_select_n <= ~req_write; // early write
            state_q        <= ST_ACC;
            // strobe falls on the next edge; the bit then needs the
            // access time and both synchroniser stages
            cnt_q          <= cyc(COL_ACC_CYC + SYNC_CYC);
          end
        end
        ST_ACC: begin
          // strobe falls a cycle after address, write select, data
          column_strobe_n <= 1'b0; // data set up at this edge
          if (cnt_q == '0 &&
              cyc_q >= cyc(CYCLE_CYC - ROW_PRE_CYC - 1)) begin
            // hold, pulse and lead times all covered by the wait
            rsp_rdata       <= wr_q ? 1'b0 : dout_s2_q;
            rsp_valid       <= 1'b1;
            column_strobe_n <= 1'b1; // output released
            // the open row belongs to one bank only
            if (req_valid && req_page && !ref_pend_q &&
                req_sel == sel_q &&
                req_addr[ROW_W-1:0] == row_q) begin
              req_ready <= 1'b1; // row strobe stays low
              cnt_q     <= cyc(PAGE_PRE_CYC);
              state_q   <= ST_PAGE_PRE;
            end else begin
              row_latch_strobe_n <= 2'b11;
              cnt_q   <= cyc(ROW_PRE_CYC);
              state_q <= ST_WRITE;
            end
          end
        end
        ST_PAGE_PRE: begin
          write_select_n <= 1'b1; // read command after rise
          if (cnt_q == '0) begin // precharge 60 ns met
            multiplexed_address_lines <= req_addr[WORD_W-1:ROW_W];
            wr_q           <= req_write;
            data_in        <= req_wdata;
            write_select_n <= ~req_write;
            cyc_q   <= cyc(CYCLE_CYC - PAGE_CYC);  // page spacing
            cnt_q   <= cyc(COL_ACC_CYC + SYNC_CYC);
            state_q <= ST_ACC;
          end
        end
        ST_WRITE: begin
          write_select_n <= 1'b1;
          state_q <= ST_PRE;
        end
        ST_PRE: begin
          // row precharge; whole cycle meets the 320 ns spacing
          if (cnt_q == '0) begin
            refresh_busy <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // mda_ctrl
`default_nettype wire

// *** testbench/mda_ctrl_sva.sv ***
// pin timing checker for the dram access controller
`timescale 1ns/1ns
`default_nettype none
module mda_ctrl_sva (
  input wire logic                       clock,
  input wire logic                       rst,
  input wire logic                       refresh_busy,
  input wire logic [1:0]                 row_latch_strobe_n,
  input wire logic                       column_strobe_n,
  input wire logic                       write_select_n,
  input wire logic [mda_pkg::ADDR_W-1:0] multiplexed_address_lines
);
  import mda_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // --------
  // precharge count
  // --------
  logic [7:0] pre_q;
  // starts at ROW_PRE_CYC: the strobes are parked high through reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) pre_q <= 8'(ROW_PRE_CYC);
    else if (!(&row_latch_strobe_n)) pre_q <= 8'h00;
    else if (pre_q != 8'hFF) pre_q <= pre_q + 8'h01;
  end
  sequence row_fall_s; $fell(&row_latch_strobe_n); endsequence
  sequence col_fall_s; $fell(column_strobe_n); endsequence
  chk_row_precharge:
  assert property (row_fall_s |-> pre_q >= ROW_PRE_CYC) else $error("pre");
  chk_row_hold:
  assert property (row_fall_s |=> $stable(multiplexed_address_lines))
    else $error("row hold");
  chk_col_hold:
  assert property (col_fall_s |=> $stable(multiplexed_address_lines) [*3])
    else $error("col hold");
  chk_wsel_steady:
  assert property (!$past(column_strobe_n) |-> $stable(write_select_n))
    else $error("wsel moved");
  chk_wsel_width:
  assert property ($fell(write_select_n) |-> !write_select_n [*4])
    else $error("wsel width");
  chk_wsel_lead:
  assert property ($rose(column_strobe_n) && !write_select_n
    |-> !$past(write_select_n, 5)) else $error("wsel lead");
  chk_page_gap:
  assert property ($rose(column_strobe_n) && !(&row_latch_strobe_n)
    |-> column_strobe_n [*6]) else $error("page gap");
  chk_refresh_col:
  assert property (refresh_busy |-> column_strobe_n) else $error("ref col");
endmodule // mda_ctrl_sva
bind mda_ctrl mda_ctrl_sva u_sva (.clock, .rst, .refresh_busy,
  .row_latch_strobe_n, .column_strobe_n, .write_select_n,
  .multiplexed_address_lines);
`default_nettype wire

// *** testbench/mda_dram_model.sv ***
// behavioural two-bank model of the multiplexed dynamic ram
`timescale 1ns/1ns
`default_nettype none
module mda_dram_model (
  input  wire logic [1:0]                 row_latch_strobe_n,
  input  wire logic                       column_strobe_n,
  input  wire logic                       write_select_n,
  input  wire logic [mda_pkg::ADDR_W-1:0] multiplexed_address_lines,
  input  wire logic                       data_in,
  output logic                            data_out
);
  import mda_pkg::*;
  logic              mem [2][2**WORD_W];
  logic [ROW_W-1:0]  row_q;
  logic [WORD_W-1:0] idx;
  logic              bank, drv, bit_q;
  // --------
  // storage and pin
  // --------
  // released pin shows the inverse bit so a stale read cannot pass
  assign data_out = drv ? bit_q : ~bit_q;
  initial begin
    {drv, bit_q, bank, row_q} = '0;
    foreach (mem[i, j]) mem[i][j] = 1'b0;
  end
  // row latched on any strobe fall; the whole row is restored
  always @(negedge (&row_latch_strobe_n)) begin
    row_q = multiplexed_address_lines;
    bank = row_latch_strobe_n[0];
  end
  // early write stores and keeps the pin released
  always @(negedge column_strobe_n) begin
    idx = {multiplexed_address_lines, row_q};
    if (!write_select_n) mem[bank][idx] = data_in;
    else begin
      bit_q = mem[bank][idx];
      #(COL_ACCESS_NS) drv = !column_strobe_n;
    end
  end
  always @(posedge column_strobe_n) drv = 1'b0;
  // delayed write: the read bit stays on the pin, the cell takes data
  always @(negedge write_select_n) begin
    if (!column_strobe_n) mem[bank][idx] = data_in;
  end
endmodule // mda_dram_model
`default_nettype wire

// *** testbench/test_multiplexed_dram_access.sv ***
// self-checking bench for the dram access controller
`timescale 1ns/1ns
`default_nettype none
module test_multiplexed_dram_access;
  import mda_pkg::*;
  logic              clock, rst, req_valid, req_write, req_page, req_sel;
  logic [WORD_W-1:0] req_addr;
  logic              req_wdata, req_ready, rsp_valid, rsp_rdata;
  logic              refresh_busy, column_strobe_n, write_select_n;
  logic              data_in, data_out;
  logic [1:0]        row_latch_strobe_n;
  logic [ADDR_W-1:0] multiplexed_address_lines;
  logic [31:0]       r;
  logic              ref_mem [int];
  logic              exp_q [$];
  logic              ref_seen = 1'b0;
  int                err_count, total_checks, cyc, seed, n_ref, n_page,
                     exp_row;
  mda_ctrl uut (.clock, .rst, .req_valid, .req_write, .req_page, .req_sel,
    .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
    .refresh_busy, .row_latch_strobe_n, .column_strobe_n,
    .write_select_n, .multiplexed_address_lines, .data_in, .data_out);
  mda_dram_model u_mem (.row_latch_strobe_n, .column_strobe_n,
    .write_select_n, .multiplexed_address_lines, .data_in, .data_out);
  // --------
  // clock, watchdog, tasks
  // --------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // watchdog well above the expected run; outputs are looked at a
  // nanosecond after each edge, once they have settled
  always @(posedge clock) begin
    #1;
    cyc++;
    if (refresh_busy === 1'b1 && !ref_seen) begin
      exp_row = n_ref % REFRESH_ROWS;
      check_val("ref row", multiplexed_address_lines, exp_row);
      n_ref++;
    end
    ref_seen = (refresh_busy === 1'b1);
    // a page continuation is taken while a row strobe is still low
    if (req_ready === 1'b1 && row_latch_strobe_n !== 2'b11) n_page++;
    if (rsp_valid === 1'b1 && exp_q.size() == 0)
      check_val("spare response", 1'b1, 1'b0);
    else if (rsp_valid === 1'b1)
      check_val("rsp_rdata", rsp_rdata, exp_q.pop_front());
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic check_val(input string what, input logic [31:0] seen,
                           input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // called a nanosecond after an edge; holds the request until taken
  // and its fields until the column strobe has fallen, so the next
  // call stands in time for a page continuation at the column end
  task automatic do_op(input logic w, p, s, input logic [13:0] a,
                       input logic d);
    int   n, k;
    logic e;
    k = {s, a};
    e = w ? 1'b0 : (ref_mem.exists(k) ? ref_mem[k] : 1'b0);
    if (w) ref_mem[k] = d;
    {req_valid, req_write, req_page, req_sel} = {1'b1, w, p, s};
    {req_addr, req_wdata} = {a, d};
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    exp_q.push_back(e);
    req_valid = 1'b0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (column_strobe_n !== 1'b0 && n < 3000);
    if (n >= 3000) err_count++;
  endtask
  // wait until every issued operation has answered
  task automatic drain(input string what);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check_val("pending answers", exp_q.size(), 0);
    $display("test %s done", what);
  endtask
  initial begin
    seed = 36;
    {rst, req_valid, req_write, req_page, req_sel, req_wdata} = 6'h20;
    req_addr = '0;
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    @(posedge clock);
    #1;
    // random traffic over a small address pool so reads hit writes
    repeat (60) begin
      r = $random(seed);
      do_op(r[0], r[1], r[2], r[16:3] & 14'h0C63, r[17]);
    end
    drain("random");
    // corner rows and columns in both banks, written then read
    for (int i = 0; i < 8; i++) begin
      r = i;
      do_op(1'b1, 1'b0, r[2], {{7{r[0]}}, {7{r[1]}}}, ~r[0]);
      do_op(1'b0, r[0], r[2], {{7{r[0]}}, {7{r[1]}}}, 1'b0);
    end
    drain("corners");
    // one open row: eight columns written, then read back, all as page
    // continuations after the first unless a refresh falls due in between
    r = $random(seed);
    for (int i = 0; i < 16; i++)
      do_op(i < 8, 1'b1, 1'b1, {i[2:0], 4'h9, 7'h2A}, r[i % 8]);
    drain("page");
    check_val("page taken", n_page > 8, 1'b1);
    repeat (600) @(posedge clock);
    check_val("refresh", n_ref + 2 >= cyc / REFRESH_CYC_DEF, 1'b1);
    $display("test refresh done");
    print_verdict();
  end
endmodule // test_multiplexed_dram_access
`default_nettype wire
